// [shared/ati_pkg.sv]
// Purpose: constants for the asynchronous terminal interface
// Assumes: 125 MHz system clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package ati_pkg;
   // clock rate
   localparam int unsigned CLK_HZ         = 125_000_000;
   // register byte offsets
   localparam logic [7:0]  OFF_TXDATA     = 8'h00;
   localparam logic [7:0]  OFF_RXDATA     = 8'h04;
   localparam logic [7:0]  OFF_CTRL       = 8'h08;
   localparam logic [7:0]  OFF_LINE       = 8'h0C;
   localparam logic [7:0]  OFF_IRQ_STAT   = 8'h10;
   localparam logic [7:0]  OFF_IRQ_EN     = 8'h14;
   localparam logic [7:0]  OFF_IRQ_CLR    = 8'h18;
   localparam logic [7:0]  OFF_CONFIG     = 8'h1C;
   // interrupt status bit positions
   localparam int unsigned IRQ_TX_BIT     = 0;
   localparam int unsigned IRQ_RX_BIT     = 1;
   localparam int unsigned IRQ_ST_BIT     = 2;
   localparam int unsigned IRQ_W          = 3;
   // control bit positions
   localparam int unsigned CTRL_RTS_BIT   = 0;
   localparam int unsigned CTRL_DTR_BIT   = 1;
   // line status bit positions
   localparam int unsigned LINE_TXBUSY    = 0;
   localparam int unsigned LINE_RXFULL    = 1;
   localparam int unsigned LINE_OVERRUN   = 2;
   localparam int unsigned LINE_FRAMEERR  = 3;
   localparam int unsigned LINE_CTS       = 4;
   localparam int unsigned LINE_DSR       = 5;
   localparam int unsigned LINE_DCD       = 6;
   // reset values
   localparam logic [1:0]  CTRL_RESET     = 2'h0;
   localparam logic [2:0]  IRQ_EN_RESET   = 3'h0;
   // frame lengths
   localparam int unsigned FRAME_LONG     = 11;
   localparam int unsigned FRAME_SHORT    = 10;
   localparam int unsigned DATA_BITS      = 8;
   // baud select codes and rates
   localparam int unsigned N_RATES        = 9;
   localparam logic [3:0]  RATE_110       = 4'h0;
   localparam int unsigned BAUD_TABLE [N_RATES] = '{110, 150, 300, 600, 1200, 1760, 2400, 4800, 9600};
   // oversampling of the receiver
   localparam int unsigned OVERSAMPLE     = 16;
   localparam int unsigned OVS_MID        = 8;
   // sixteenth-bit tick period in system clocks (rounded down); 110 baud needs more than 16 bits
   function automatic logic [19:0] tick_div(input logic [3:0] sel, input int unsigned clk_hz);
      int unsigned r;
      r = BAUD_TABLE[(sel < 4'(N_RATES)) ? sel : 4'h0];
      return 20'(clk_hz / (r * OVERSAMPLE));
   endfunction
endpackage

// [hw/ati_rx.sv]
// Purpose: serial receiver of one character frame
// Assumes: tick_en is a 16x bit-rate enable pulse, line idles marking (1)
// Notes:   data bits arrive lsb first; stop bits checked for marking
`timescale 1ns/1ps
`default_nettype none
module ati_rx
   import ati_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // timing
   input  wire logic       tick_en,
   input  wire logic       long_frame,
   // serial line
   input  wire logic       rxd,
   // character out
   output logic [7:0]      rx_byte,
   output logic            rx_done,
   output logic            rx_ferr
);
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_SHIFT = 3'b010,
      RX_STOP  = 3'b100
   } ati_rxst_type;

   ati_rxst_type st_reg;
   logic [3:0]   ovs_reg;
   logic [3:0]   bit_reg;
   logic [7:0]   sh_reg;
   logic         ferr_reg;

   // frame walk: start check, eight data bits, one or two stop bits
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg   <= RX_IDLE;
         ovs_reg  <= 4'h0;
         bit_reg  <= 4'h0;
         sh_reg   <= 8'h00;
         ferr_reg <= 1'b0;
         rx_byte  <= 8'h00;
         rx_done  <= 1'b0;
         rx_ferr  <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (tick_en) begin
            unique case (st_reg)
               RX_IDLE: begin
                  // space on an idle line opens a frame
                  if (!rxd) begin
                     ovs_reg <= ovs_reg + 4'h1;
                     if (ovs_reg == 4'(OVS_MID - 1)) begin
                        st_reg   <= RX_SHIFT;
                        ovs_reg  <= 4'h0;
                        bit_reg  <= 4'h0;
                        ferr_reg <= 1'b0;
                     end
                  end else begin
                     ovs_reg <= 4'h0;
                  end
               end
               RX_SHIFT: begin
                  ovs_reg <= ovs_reg + 4'h1;
                  if (ovs_reg == 4'hF) begin
                     sh_reg  <= {rxd, sh_reg[7:1]};
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'(DATA_BITS - 1)) begin
                        st_reg  <= RX_STOP;
                        bit_reg <= 4'h0;
                     end
                  end
               end
               RX_STOP: begin
                  ovs_reg <= ovs_reg + 4'h1;
                  if (ovs_reg == 4'hF) begin
                     // second stop bit only on the long frame
                     if (!rxd)
                        ferr_reg <= 1'b1;
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == (long_frame ? 4'h1 : 4'h0)) begin
                        st_reg  <= RX_IDLE;
                        ovs_reg <= 4'h0;
                        rx_byte <= sh_reg;
                        rx_ferr <= ferr_reg | ~rxd;
                        rx_done <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [hw/ati_top.sv]
// Purpose: full duplex asynchronous terminal interface behind an APB slave
// Assumes: one 125 MHz clock; straps held static; line pins synchronous
// Notes:   rate, line type and interrupt option are wiring straps
`timescale 1ns/1ps
`default_nettype none
module ati_top
   import ati_pkg::*;
#(
   parameter int unsigned ADDR_W      = 8,
   parameter int unsigned CLK_FREQ_HZ = CLK_HZ
)(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // wiring straps
   input  wire logic [3:0]        rate_sel,
   input  wire logic              eia_mode,
   input  wire logic              irq_strap,
   // terminal line
   output logic                   txd,
   input  wire logic              rxd,
   output logic                   rts,
   output logic                   dtr,
   input  wire logic              cts,
   input  wire logic              dsr,
   input  wire logic              dcd,
   // interrupt
   output logic                   irq
);
   // refuse a decoder or divider that cannot serve the map and every rate
   if (ADDR_W < 6 || CLK_FREQ_HZ < 2 * BAUD_TABLE[N_RATES-1] * OVERSAMPLE
       || CLK_FREQ_HZ / (BAUD_TABLE[0] * OVERSAMPLE) >= 32'h0010_0000) begin : g_bad_param
      $error("ati_top: address width or clock rate not supported");
   end

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_SHIFT = 3'b010,
      TX_STOP  = 3'b100
   } ati_txst_type;

   // strap capture after reset release
   logic [3:0]   rate_reg;
   logic         eia_reg;
   logic         irqopt_reg;
   logic         long_frame;
   // tick divider
   logic [19:0]  div_reg;
   logic         tick_reg;
   // transmitter
   ati_txst_type txst_reg;
   logic [3:0]   txovs_reg;
   logic [3:0]   txbit_reg;
   logic [7:0]   txsh_reg;
   logic         tx_done;
   // receiver
   logic [7:0]   rx_byte;
   logic         rx_done;
   logic         rx_ferr;
   logic [7:0]   rxdata_reg;
   logic         rxfull_reg;
   logic         ovr_reg;
   logic         ferr_reg;
   // control, modem status, interrupts
   logic [1:0]   ctrl_reg;
   logic [2:0]   mdm_reg;
   logic         st_chg;
   logic [2:0]   istat_reg;
   logic [2:0]   ien_reg;
   logic [2:0]   iset;
   // bus decode
   logic         acc;
   logic         wr_acc;
   logic         rd_acc;
   logic         wr_tx;
   logic         rd_rx;
   logic         known;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return a[4:0] == off[4:0] && a[ADDR_W-1:5] == '0;
   endfunction

   // bus strobes: one access cycle, zero wait states
   assign acc    = psel & penable;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign wr_tx  = wr_acc & hit(paddr, OFF_TXDATA) & (txst_reg == TX_IDLE);
   assign rd_rx  = rd_acc & hit(paddr, OFF_RXDATA);
   assign known  = hit(paddr, OFF_TXDATA) | hit(paddr, OFF_RXDATA) | hit(paddr, OFF_CTRL)
                 | hit(paddr, OFF_LINE) | hit(paddr, OFF_IRQ_STAT) | hit(paddr, OFF_IRQ_EN)
                 | hit(paddr, OFF_IRQ_CLR) | hit(paddr, OFF_CONFIG);
   assign long_frame = (rate_reg == RATE_110);

   // straps latched every cycle after release; wiring is static
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rate_reg   <= RATE_110;
         eia_reg    <= 1'b0;
         irqopt_reg <= 1'b0;
      end else begin
         rate_reg   <= (rate_sel < 4'(N_RATES)) ? rate_sel : RATE_110;
         eia_reg    <= eia_mode;
         irqopt_reg <= irq_strap;
      end
   end

   // sixteenth-bit enable pulse from the wired rate
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         div_reg  <= 20'h0_0000;
         tick_reg <= 1'b0;
      end else if (div_reg >= tick_div(rate_reg, CLK_FREQ_HZ) - 20'h0_0001) begin
         div_reg  <= 20'h0_0000;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 20'h0_0001;
         tick_reg <= 1'b0;
      end
   end

   // transmitter: idle marking, start, 8 data lsb first, stop bits
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         txst_reg  <= TX_IDLE;
         txovs_reg <= 4'h0;
         txbit_reg <= 4'h0;
         txsh_reg  <= 8'h00;
         txd       <= 1'b1;
         tx_done   <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (wr_tx) begin
            txst_reg  <= TX_SHIFT;
            txsh_reg  <= pwdata[7:0];
            txovs_reg <= 4'h0;
            txbit_reg <= 4'h0;
            txd       <= 1'b0; // start bit
         end else if (tick_en_tx()) begin
            unique case (txst_reg)
               TX_IDLE: txd <= 1'b1;
               TX_SHIFT: begin
                  txovs_reg <= txovs_reg + 4'h1;
                  if (txovs_reg == 4'hF) begin
                     txd       <= txsh_reg[0];
                     txsh_reg  <= {1'b0, txsh_reg[7:1]};
                     txbit_reg <= txbit_reg + 4'h1;
                     if (txbit_reg == 4'(DATA_BITS)) begin
                        txd       <= 1'b1; // first stop bit
                        txst_reg  <= TX_STOP;
                        txbit_reg <= 4'h0;
                     end
                  end
               end
               TX_STOP: begin
                  txovs_reg <= txovs_reg + 4'h1;
                  if (txovs_reg == 4'hF) begin
                     txbit_reg <= txbit_reg + 4'h1;
                     if (txbit_reg == (long_frame ? 4'h1 : 4'h0)) begin
                        txst_reg <= TX_IDLE;
                        tx_done  <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   function automatic logic tick_en_tx();
      return tick_reg;
   endfunction

   ati_rx u_rx (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .tick_en    (tick_reg),
      .long_frame (long_frame),
      .rxd        (rxd),
      .rx_byte    (rx_byte),
      .rx_done    (rx_done),
      .rx_ferr    (rx_ferr)
   );

   // received character holding register; new frame beats the read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rxdata_reg <= 8'h00;
         rxfull_reg <= 1'b0;
         ovr_reg    <= 1'b0;
         ferr_reg   <= 1'b0;
      end else if (rx_done) begin
         rxdata_reg <= rx_byte;
         rxfull_reg <= 1'b1;
         ovr_reg    <= rxfull_reg & ~rd_rx;
         ferr_reg   <= rx_ferr;
      end else if (rd_rx) begin
         rxfull_reg <= 1'b0;
         ovr_reg    <= 1'b0;
      end
   end

   // terminal control outputs, driven by software
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= CTRL_RESET;
         rts      <= 1'b0;
         dtr      <= 1'b0;
      end else begin
         if (wr_acc && hit(paddr, OFF_CTRL))
            ctrl_reg <= pwdata[1:0];
         rts <= ctrl_reg[CTRL_RTS_BIT];
         dtr <= ctrl_reg[CTRL_DTR_BIT];
      end
   end

   // modem status history for change detection
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         mdm_reg <= 3'h0;
      else
         mdm_reg <= {dcd, dsr, cts};
   end
   assign st_chg = eia_reg & (mdm_reg != {dcd, dsr, cts});

   // sticky status; set wins over write-one-to-clear
   assign iset = {st_chg, rx_done, tx_done};
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         istat_reg <= 3'h0;
         ien_reg   <= IRQ_EN_RESET;
      end else begin
         if (wr_acc && hit(paddr, OFF_IRQ_EN))
            ien_reg <= pwdata[IRQ_W-1:0];
         if (wr_acc && hit(paddr, OFF_IRQ_CLR))
            istat_reg <= (istat_reg & ~pwdata[IRQ_W-1:0]) | iset;
         else
            istat_reg <= istat_reg | iset;
      end
   end

   // interrupt line: only when wired
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= irqopt_reg & |(istat_reg & ien_reg);
   end

   // apb answer registered in the setup cycle, presented in the access cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~known;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (hit(paddr, OFF_RXDATA))
               prdata <= {24'h00_0000, rxdata_reg};
            else if (hit(paddr, OFF_CTRL))
               prdata <= {30'h0000_0000, ctrl_reg};
            else if (hit(paddr, OFF_LINE))
               prdata <= {25'h000_0000, dcd, dsr, cts, ferr_reg, ovr_reg, rxfull_reg,
                          (txst_reg != TX_IDLE)};
            else if (hit(paddr, OFF_IRQ_STAT))
               prdata <= {29'h0000_0000, istat_reg};
            else if (hit(paddr, OFF_IRQ_EN))
               prdata <= {29'h0000_0000, ien_reg};
            else if (hit(paddr, OFF_CONFIG))
               prdata <= {25'h000_0000, long_frame, irqopt_reg, eia_reg, rate_reg};
         end
      end
   end
endmodule
`default_nettype wire

// [dv/ati_checker.sv]
// Purpose: port assertions for the terminal interface
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module from the bench
`timescale 1ns/1ps
`default_nettype none
module ati_checker
   import ati_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)(
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              nrst,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // strap, line and interrupt
   input wire logic              irq_strap,
   input wire logic              txd,
   input wire logic              rts,
   input wire logic              dtr,
   input wire logic              irq
);
   logic       wr_ok;
   logic [1:0] ctrl_w;
   logic [2:0] en_w;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // completed write
   assign wr_ok = psel && penable && pwrite && pready;
   // shadows of control and enable words
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_w <= 2'h0;
         en_w <= 3'h0;
      end else begin
         if (wr_ok && paddr == ADDR_W'(OFF_CTRL)) ctrl_w <= pwdata[1:0];
         if (wr_ok && paddr == ADDR_W'(OFF_IRQ_EN)) en_w <= pwdata[2:0];
      end
   end
   a_ready_access: assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   a_ready_only: assert property (!(psel && penable) |-> !pready)
      else $error("ready outside access cycle");
   a_unmapped_err: assert property (psel && penable && pready
      |-> pslverr == (paddr > ADDR_W'(OFF_CONFIG) || paddr[1:0] != 2'h0)) else $error("wrong error response");
   a_ctrl_follow: assert property (wr_ok && paddr == ADDR_W'(OFF_CTRL)
      |=> ##1 {dtr, rts} == ctrl_w) else $error("control pins do not follow");
   a_irq_strap_off: assert property (!irq_strap [*3] |-> !irq)
      else $error("irq without strap");
   a_irq_masked: assert property ((en_w == 3'h0) [*3] |-> !irq)
      else $error("irq while all masked");
   a_txd_idle: assert property ($rose(nrst) |-> txd)
      else $error("line not marking after reset");
   a_start_width: assert property ($fell(txd) |-> !txd [*8])
      else $error("start bit too short");
   c_tx_write: cover property (wr_ok && paddr == ADDR_W'(OFF_TXDATA));
   c_irq_rise: cover property ($rose(irq));
   c_err_resp: cover property (pready && pslverr);
endmodule
`default_nettype wire

// [dv/ati_term_model.sv]
// Purpose: behavioural terminal on the serial line
// Assumes: bit time given in system clocks
// Notes:   line idles marking, data lsb first
`timescale 1ns/1ps
`default_nettype none
module ati_term_model #(
   parameter int BIT   = 13008,
   parameter int NBITS = 10
)(
   // clock
   input wire logic       sys_clk,
   // serial line
   input wire logic       txd,
   output logic           rxd,
   // bench side
   input wire logic [7:0] snd_byte,
   input wire logic       snd_go,
   output logic           snd_done,
   output logic [7:0]     got_byte,
   output logic [7:0]     got_cnt,
   output logic           got_ok
);
   // capture frames from the block, mid-bit samples
   initial begin
      got_cnt = 8'h00;
      got_ok = 1'b0;
      got_byte = 8'h00;
      forever begin
         @(negedge txd);
         repeat (BIT / 2) @(posedge sys_clk);
         got_ok = !txd;
         for (int i = 0; i < NBITS - 1; i++) begin
            repeat (BIT) @(posedge sys_clk);
            if (i < 8) got_byte[i] = txd;
            else got_ok = got_ok & txd;
         end
         got_cnt = got_cnt + 8'h01;
      end
   end
   // send one frame per request, then rest marking
   initial begin
      rxd = 1'b1;
      snd_done = 1'b0;
      forever begin
         @(posedge snd_go);
         snd_done = 1'b0;
         for (int i = 0; i < NBITS; i++) begin
            @(posedge sys_clk);
            rxd <= (i == 0) ? 1'b0 : (i < 9) ? snd_byte[i - 1] : 1'b1;
            repeat (BIT - 1) @(posedge sys_clk);
         end
         snd_done = 1'b1;
      end
   end
endmodule
`default_nettype wire

// [dv/async_terminal_interface_test.sv]
// Purpose: self-checking bench for the terminal interface
// Assumes: 9600 baud for frame traffic, divider told a slower clock
// Notes:   status lines driven by the bench
`timescale 1ns/1ps
`default_nettype none
module async_terminal_interface_test
   import ati_pkg::*;
;
   // scaled divider clock keeps one frame well inside the run length
   localparam int unsigned TB_CLK_HZ = 12_500_000;
   localparam int BIT = int'(OVERSAMPLE * (TB_CLK_HZ / (9600 * OVERSAMPLE)));
   logic        sys_clk, pready, pslverr, txd, rxd, rts, dtr, irq, err;
   logic        nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        eia_mode = 1'b0, irq_strap = 1'b0, snd_go = 1'b0;
   logic        snd_done, got_ok;
   logic [3:0]  rate_sel = 4'h0;
   logic [2:0]  st = 3'h0;
   logic [7:0]  paddr = 8'h00, snd_byte = 8'h00, got_byte, got_cnt;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   int          n_mismatch = 0, num_checks = 0;
   ati_top #(.CLK_FREQ_HZ(TB_CLK_HZ)) DUT (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rate_sel, .eia_mode, .irq_strap, .txd, .rxd, .rts,
      .dtr, .cts(st[0]), .dsr(st[1]), .dcd(st[2]), .irq);
   ati_term_model #(.BIT(BIT), .NBITS(FRAME_SHORT)) u_term (.sys_clk, .txd, .rxd, .snd_byte,
      .snd_go, .snd_done, .got_byte, .got_cnt, .got_ok);
   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask
   task automatic rst(input logic [3:0] r, input logic e, input logic s);
      nrst <= 1'b0;
      rate_sel <= r;
      eia_mode <= e;
      irq_strap <= s;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   // test sequence
   initial begin
      @(posedge sys_clk);
      for (int s = 0; s < 9; s++) begin
         rst(4'(s), s[0], s[1]);
         rdchk(OFF_CONFIG, {25'h0, s == 0, s[1], s[0], 4'(s)});
         apb(1'b1, OFF_IRQ_EN, 32'h0000_0007);
         st <= st ^ 3'b010;
         repeat (4) @(posedge sys_clk);
         rdchk(OFF_IRQ_STAT, {29'h0, s[0], 2'b00});
         chk({31'h0, irq}, {31'h0, s[0] & s[1]});
      end
      rst(4'hC, 1'b0, 1'b0);
      rdchk(OFF_CONFIG, 32'h0000_0040);
      $display("test straps done");
      st <= 3'b000;
      rst(4'h8, 1'b1, 1'b1);
      rdchk(OFF_CTRL, 32'h0000_0000);
      rdchk(OFF_IRQ_EN, 32'h0000_0000);
      rdchk(OFF_LINE, 32'h0000_0000);
      rdchk(8'h20, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b1, OFF_CTRL, 32'h0000_0003);
      rdchk(OFF_CTRL, 32'h0000_0003);
      chk({30'h0, dtr, rts}, 32'h0000_0003);
      apb(1'b1, OFF_IRQ_EN, 32'h0000_0007);
      st <= 3'b001;
      repeat (4) @(posedge sys_clk);
      rdchk(OFF_LINE, 32'h0000_0010);
      rdchk(OFF_IRQ_STAT, 32'h0000_0004);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b1, OFF_IRQ_CLR, 32'h0000_0004);
      rdchk(OFF_IRQ_STAT, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test status done");
      apb(1'b1, OFF_TXDATA, 32'h0000_00A5);
      snd_byte <= 8'h3C;
      snd_go <= 1'b1;
      rdchk(OFF_LINE, 32'h0000_0011);
      apb(1'b1, OFF_TXDATA, 32'h0000_0000);
      snd_go <= 1'b0;
      while (!(snd_done === 1'b1 && got_cnt === 8'h01)) begin
         @(posedge sys_clk);
      end
      repeat (BIT) @(posedge sys_clk);
      chk({24'h0, got_byte}, 32'h0000_00A5);
      chk({31'h0, got_ok}, 32'h0000_0001);
      rdchk(OFF_IRQ_STAT, 32'h0000_0003);
      rdchk(OFF_RXDATA, 32'h0000_003C);
      rdchk(OFF_LINE, 32'h0000_0010);
      chk({24'h0, got_cnt}, 32'h0000_0001);
      apb(1'b1, OFF_IRQ_CLR, 32'h0000_0003);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test duplex done");
      tally_and_finish();
   end
endmodule
bind ati_top ati_checker #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .nrst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .irq_strap, .txd, .rts, .dtr, .irq);
`default_nettype wire
